// file: src/wtm_pkg.sv
/*
  wtm_pkg: constants shared by the wake-up timer and measurement block.
  Assumes a single 125 MHz core clock and register access over AXI4-Lite
  with 32-bit data; 8-bit registers sit in the low byte of each word.
*/
package wtm_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FINE_STEP_MS = 10;      // short range step
  localparam int unsigned COARSE_STEP_MS = 100;   // long range step
  // cycles per fine step, derived from the clock rate
  localparam int unsigned FINE_STEP_CYCLES = CLK_HZ / 1000 * FINE_STEP_MS;
  // fine steps per coarse step
  localparam int unsigned FINE_PER_COARSE = COARSE_STEP_MS / FINE_STEP_MS;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAKE_CTRL = 8'h32;
  localparam logic [7:0] IDX_AMP_CFG = 8'h33;
  localparam logic [7:0] IDX_AMP_REF = 8'h34;
  localparam logic [7:0] IDX_AMP_AVG = 8'h35;
  localparam logic [7:0] IDX_AMP_RES = 8'h36;
  localparam logic [7:0] IDX_PC_DELTA = 8'h3C;
  localparam logic [7:0] IDX_PH_REF = 8'h3D;
  localparam logic [7:0] IDX_CAP_REF = 8'h3E;
  localparam logic [7:0] IDX_PH_RES = 8'h3F;
  localparam logic [7:0] IDX_CAP_RES = 8'h40;
  localparam int unsigned ADDR_W = 10;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // wake-up timer control fields
  localparam int unsigned WC_RANGE = 7;
  localparam int unsigned WC_TOUT_HI = 6;
  localparam int unsigned WC_TOUT_LO = 4;
  localparam int unsigned WC_EVERY = 3;

  // amplitude configuration fields
  localparam int unsigned AC_DELTA_HI = 7;
  localparam int unsigned AC_DELTA_LO = 4;
  localparam int unsigned AC_INCL = 3;
  localparam int unsigned AC_WEIGHT_HI = 2;
  localparam int unsigned AC_WEIGHT_LO = 1;
  localparam int unsigned AC_REF_SEL = 0;

  // phase/capacitance delta register fields
  localparam int unsigned PC_PH_HI = 7;
  localparam int unsigned PC_PH_LO = 4;
  localparam int unsigned PC_CAP_HI = 3;
  localparam int unsigned PC_CAP_LO = 0;

  // channel numbers match the enable bit positions in the control register
  localparam int unsigned CH_CAP = 0;
  localparam int unsigned CH_PH = 1;
  localparam int unsigned CH_AMP = 2;
  localparam int unsigned NUM_CH = 3;

  // weight code 00 means divide by 4, i.e. shift by 2
  localparam logic [2:0] WEIGHT_SHIFT_BASE = 3'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // wake-up timer states
  typedef enum {TMR_IDLE, TMR_RUN} wtm_tmr_e;

endpackage : wtm_pkg

// file: src/wtm_tick_gen.sv
/*
  wtm_tick_gen: divides the core clock into a one-cycle enable pulse per
  fine wake-up step. Assumes run and clear come from logic on core_clk.
*/
`timescale 1ns/100ps
module wtm_tick_gen #(
  parameter int unsigned STEP_CYCLES = wtm_pkg::FINE_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  output logic tick
);

  localparam int unsigned CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

  logic [CW-1:0] cnt_q; // cycles inside the current step

  // free count while running; clear restarts the step from zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (clear || !run) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule : wtm_tick_gen

// file: src/wtm_auto_avg.sv
/*
  wtm_auto_avg: running average of amplitude results with a selectable
  weight. Assumes sample_valid is a one-cycle pulse on core_clk.
*/
`timescale 1ns/100ps
module wtm_auto_avg (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic [7:0] sample,
  input wire logic [1:0] weight_sel,
  input wire logic keep_sample,
  output logic [7:0] avg_q
);

  logic signed [9:0] diff;    // new minus average
  logic signed [9:0] step;    // diff scaled by the weight
  logic [2:0] shift;          // 2..5 for weights 4..32
  logic signed [9:0] sum;     // updated average before cut

  // avg + (new - avg) / weight; arithmetic shift rounds toward minus
  // infinity, which is cheap but can leave the average up to weight minus one lsb low
  always_comb begin
    shift = wtm_pkg::WEIGHT_SHIFT_BASE + {1'b0, weight_sel}; // [R9]
    diff = $signed({2'b00, sample}) - $signed({2'b00, avg_q});
    step = diff >>> shift;
    sum = $signed({2'b00, avg_q}) + step; // [R11]
  end

  // skipped samples leave the average untouched
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avg_q <= wtm_pkg::RST_REG;
    end else if (sample_valid && keep_sample) begin // [R8]
      avg_q <= sum[7:0];
    end
  end

endmodule : wtm_auto_avg

// file: src/wtm_wakeup_timer.sv
/*
  wtm_wakeup_timer: low-power wake-up timer with amplitude, phase and
  capacitance wake measurements, registers over AXI4-Lite.
  Assumes the measurement front end runs on core_clk: it takes a one-cycle
  request and later answers with a one-cycle done and the 8-bit result.
  Interrupt outputs are one-cycle pulses to an outside interrupt collector.
*/
// Added by the designer: the AXI4-Lite slave port.
// Behaviour
// [R1] range bit picks 100 ms or 10 ms steps
// [R2] period is (code+1) steps of the range
// [R3] every-timeout bit raises timer interrupt each expiry
// [R4] amplitude bit measures, interrupts on excess difference
// [R5] phase bit measures, interrupts on excess difference
// [R6] capacitance bit measures, interrupts on excess difference
// [R7] bits 7..4 hold the amplitude delta threshold
// [R8] include bit keeps triggering result in average
// [R9] weight code selects 4, 8, 16 or 32
// [R10] reference select 0 compares against reference register
// [R11] reference select 1 compares against running average
`timescale 1ns/100ps
module wtm_wakeup_timer #(
  parameter int unsigned FINE_STEP_CYCLES = wtm_pkg::FINE_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [wtm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [wtm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurement front end, bit index is the channel number
  output logic [2:0] meas_req,
  input wire logic [2:0] meas_done,
  input wire logic [7:0] amp_result,
  input wire logic [7:0] phase_result,
  input wire logic [7:0] cap_result,
  // event pulses
  output logic irq_wake_timer,
  output logic irq_amp_wake,
  output logic irq_phase_wake,
  output logic irq_cap_wake
);

  // software registers
  logic [7:0] wake_ctrl_q;     // wake_timer_control
  logic [7:0] amp_cfg_q;       // amplitude_measure_config
  logic [7:0] amp_ref_q;       // amplitude reference
  logic [7:0] pc_delta_q;      // phase and capacitance deltas
  logic [7:0] ph_ref_q;        // phase reference
  logic [7:0] cap_ref_q;       // capacitance reference

  // AXI write side holding registers
  logic aw_held_q;
  logic [wtm_pkg::ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] w_byte_q;        // only the low byte carries data
  logic w_lane0_q;             // low byte strobe
  logic wr_fire;               // address and data both present
  logic [7:0] wr_idx;
  logic wr_en;                 // low byte written this cycle

  // decoded control fields
  logic range_fine;
  logic [2:0] tout_code;
  logic every_irq;
  logic timer_run;
  logic [3:0] amplitude_delta_threshold;
  logic include_trigger_in_average;
  logic [1:0] average_weight_select;
  logic reference_source_select;

  // timer
  wtm_pkg::wtm_tmr_e tmr_q;
  logic [6:0] tick_cnt_q;      // fine steps counted in this period
  logic [6:0] period_steps;    // fine steps in a full period
  logic [6:0] code_plus1;
  logic fine_tick;
  logic timeout;
  logic ctrl_wr;

  // measurements
  logic [2:0] pending_q;       // request out, answer not yet back
  logic [7:0] res_q [wtm_pkg::NUM_CH];
  logic [7:0] ch_result [wtm_pkg::NUM_CH];
  logic [7:0] ch_ref [wtm_pkg::NUM_CH];
  logic [3:0] ch_delta [wtm_pkg::NUM_CH];
  logic [2:0] ch_hit;          // difference beyond delta this cycle
  logic [2:0] ch_take;         // accepted answer this cycle
  logic [2:0] wake_irq_q;
  logic [7:0] amp_avg;

  // control field decode
  always_comb begin
    range_fine = wake_ctrl_q[wtm_pkg::WC_RANGE];
    tout_code = wake_ctrl_q[wtm_pkg::WC_TOUT_HI:wtm_pkg::WC_TOUT_LO];
    every_irq = wake_ctrl_q[wtm_pkg::WC_EVERY];
    amplitude_delta_threshold = amp_cfg_q[wtm_pkg::AC_DELTA_HI:wtm_pkg::AC_DELTA_LO]; // [R7]
    include_trigger_in_average = amp_cfg_q[wtm_pkg::AC_INCL];
    average_weight_select = amp_cfg_q[wtm_pkg::AC_WEIGHT_HI:wtm_pkg::AC_WEIGHT_LO];
    reference_source_select = amp_cfg_q[wtm_pkg::AC_REF_SEL];
  end

  // the timer only runs when some wake action is armed; idling it
  // otherwise avoids pointless expiries while software sets things up
  assign timer_run = every_irq || (|wake_ctrl_q[wtm_pkg::NUM_CH-1:0]);

  // period length in fine steps: one step per code in the short range,
  // ten per code in the long range
  always_comb begin
    code_plus1 = {4'h0, tout_code} + 7'h01; // [R2]
    if (range_fine) begin // [R1]
      period_steps = code_plus1;
    end else begin
      period_steps = 7'(code_plus1 * 7'(wtm_pkg::FINE_PER_COARSE));
    end
  end

  // fine step divider; a control write restarts the step as well
  wtm_tick_gen #(
    .STEP_CYCLES(FINE_STEP_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(timer_run),
    .clear(ctrl_wr),
    .tick(fine_tick)
  );

  assign timeout = (tmr_q == wtm_pkg::TMR_RUN) && fine_tick
                   && (tick_cnt_q == period_steps - 7'h01);

  // period counter; a new setting takes effect from a fresh period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tmr_q <= wtm_pkg::TMR_IDLE;
      tick_cnt_q <= '0;
    end else begin
      unique case (tmr_q)
        wtm_pkg::TMR_IDLE: begin
          tick_cnt_q <= '0;
          if (timer_run && !ctrl_wr) begin
            tmr_q <= wtm_pkg::TMR_RUN;
          end
        end
        wtm_pkg::TMR_RUN: begin
          if (!timer_run || ctrl_wr) begin
            // restart so the new period is counted in full
            tmr_q <= wtm_pkg::TMR_IDLE;
            tick_cnt_q <= '0;
          end else if (timeout) begin // [R2]
            tick_cnt_q <= '0;
          end else if (fine_tick) begin
            tick_cnt_q <= tick_cnt_q + 7'h01;
          end
        end
      endcase
    end
  end

  // timer event pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_wake_timer <= 1'b0;
    end else begin
      irq_wake_timer <= timeout && every_irq; // [R3]
    end
  end

  // per-channel inputs gathered into arrays for the loop below
  always_comb begin
    ch_result[wtm_pkg::CH_AMP] = amp_result;
    ch_result[wtm_pkg::CH_PH] = phase_result;
    ch_result[wtm_pkg::CH_CAP] = cap_result;
    if (reference_source_select) begin // [R11]
      ch_ref[wtm_pkg::CH_AMP] = amp_avg;
    end else begin // [R10]
      ch_ref[wtm_pkg::CH_AMP] = amp_ref_q;
    end
    ch_ref[wtm_pkg::CH_PH] = ph_ref_q;
    ch_ref[wtm_pkg::CH_CAP] = cap_ref_q;
    ch_delta[wtm_pkg::CH_AMP] = amplitude_delta_threshold; // [R7]
    ch_delta[wtm_pkg::CH_PH] = pc_delta_q[wtm_pkg::PC_PH_HI:wtm_pkg::PC_PH_LO];
    ch_delta[wtm_pkg::CH_CAP] = pc_delta_q[wtm_pkg::PC_CAP_HI:wtm_pkg::PC_CAP_LO];
  end

  // one request, compare and interrupt path per measurement channel
  for (genvar ch = 0; ch < wtm_pkg::NUM_CH; ch++) begin : g_ch
    logic [7:0] abs_diff; // distance from the reference

    assign abs_diff = (ch_result[ch] > ch_ref[ch]) ? ch_result[ch] - ch_ref[ch]
                                                   : ch_ref[ch] - ch_result[ch];
    assign ch_hit[ch] = abs_diff > {4'h0, ch_delta[ch]};
    // answers without an open request are stray and dropped
    assign ch_take[ch] = meas_done[ch] && pending_q[ch];

    // a timeout while the previous answer is still out starts nothing,
    // so one channel never has two requests in flight
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        meas_req[ch] <= 1'b0;
        pending_q[ch] <= 1'b0;
      end else begin
        meas_req[ch] <= timeout && wake_ctrl_q[ch] && !pending_q[ch]; // [R4] [R5] [R6]
        if (meas_req[ch]) begin
          pending_q[ch] <= 1'b1;
        end else if (ch_take[ch]) begin
          pending_q[ch] <= 1'b0;
        end
      end
    end

    // result capture and wake interrupt pulse
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        res_q[ch] <= wtm_pkg::RST_REG;
        wake_irq_q[ch] <= 1'b0;
      end else begin
        wake_irq_q[ch] <= ch_take[ch] && ch_hit[ch] && wake_ctrl_q[ch]; // [R4] [R5] [R6]
        if (ch_take[ch]) begin
          res_q[ch] <= ch_result[ch];
        end
      end
    end
  end

  assign irq_amp_wake = wake_irq_q[wtm_pkg::CH_AMP];
  assign irq_phase_wake = wake_irq_q[wtm_pkg::CH_PH];
  assign irq_cap_wake = wake_irq_q[wtm_pkg::CH_CAP];

  // amplitude running average; a triggering result is kept only when
  // the include bit asks for it
  wtm_auto_avg u_avg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_valid(ch_take[wtm_pkg::CH_AMP]),
    .sample(amp_result),
    .weight_sel(average_weight_select), // [R9]
    .keep_sample(include_trigger_in_average || !ch_hit[wtm_pkg::CH_AMP]), // [R8]
    .avg_q(amp_avg)
  );

  // AXI write channel acceptance: each side is held until the pair is
  // complete and the response has been taken
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = aw_addr_q[wtm_pkg::ADDR_W-1:2];
  assign wr_en = wr_fire && w_lane0_q;
  assign ctrl_wr = wr_en && (wr_idx == wtm_pkg::IDX_WAKE_CTRL);

  // address and data capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_byte_q <= wtm_pkg::RST_REG;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wtm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= idx_mapped(wr_idx) ? wtm_pkg::RESP_OKAY : wtm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers; display registers ignore writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_ctrl_q <= wtm_pkg::RST_REG;
      amp_cfg_q <= wtm_pkg::RST_REG;
      amp_ref_q <= wtm_pkg::RST_REG;
      pc_delta_q <= wtm_pkg::RST_REG;
      ph_ref_q <= wtm_pkg::RST_REG;
      cap_ref_q <= wtm_pkg::RST_REG;
    end else if (wr_en) begin
      unique case (wr_idx)
        wtm_pkg::IDX_WAKE_CTRL: wake_ctrl_q <= w_byte_q;
        wtm_pkg::IDX_AMP_CFG: amp_cfg_q <= w_byte_q;
        wtm_pkg::IDX_AMP_REF: amp_ref_q <= w_byte_q;
        wtm_pkg::IDX_PC_DELTA: pc_delta_q <= w_byte_q;
        wtm_pkg::IDX_PH_REF: ph_ref_q <= w_byte_q;
        wtm_pkg::IDX_CAP_REF: cap_ref_q <= w_byte_q;
        default: begin
          // read-only or unmapped index: nothing stored
        end
      endcase
    end
  end

  // true for every index that answers OKAY
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == wtm_pkg::IDX_WAKE_CTRL) || (idx == wtm_pkg::IDX_AMP_CFG)
              || (idx == wtm_pkg::IDX_AMP_REF) || (idx == wtm_pkg::IDX_AMP_AVG)
              || (idx == wtm_pkg::IDX_AMP_RES) || (idx == wtm_pkg::IDX_PC_DELTA)
              || (idx == wtm_pkg::IDX_PH_REF) || (idx == wtm_pkg::IDX_CAP_REF)
              || (idx == wtm_pkg::IDX_PH_RES) || (idx == wtm_pkg::IDX_CAP_RES);
  endfunction : idx_mapped

  // read mux, upper 24 bits always zero
  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    unique case (idx)
      wtm_pkg::IDX_WAKE_CTRL: read_byte = wake_ctrl_q;
      wtm_pkg::IDX_AMP_CFG: read_byte = amp_cfg_q;
      wtm_pkg::IDX_AMP_REF: read_byte = amp_ref_q;
      wtm_pkg::IDX_AMP_AVG: read_byte = amp_avg;
      wtm_pkg::IDX_AMP_RES: read_byte = res_q[wtm_pkg::CH_AMP];
      wtm_pkg::IDX_PC_DELTA: read_byte = pc_delta_q;
      wtm_pkg::IDX_PH_REF: read_byte = ph_ref_q;
      wtm_pkg::IDX_CAP_REF: read_byte = cap_ref_q;
      wtm_pkg::IDX_PH_RES: read_byte = res_q[wtm_pkg::CH_PH];
      wtm_pkg::IDX_CAP_RES: read_byte = res_q[wtm_pkg::CH_CAP];
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // read channel: one read in flight, data registered on the address edge
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= wtm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, read_byte(s_axi_araddr[wtm_pkg::ADDR_W-1:2])};
      s_axi_rresp <= idx_mapped(s_axi_araddr[wtm_pkg::ADDR_W-1:2])
                     ? wtm_pkg::RESP_OKAY : wtm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : wtm_wakeup_timer

// file: testbench/wtm_wakeup_timer_sva.sv
/*
  wtm_wakeup_timer_sva: port checker for wtm_wakeup_timer.
  Assumes one core clock and synchronous active-low reset; bound below.
*/
`timescale 1ns/100ps
module wtm_wakeup_timer_sva #(
  parameter int unsigned FINE_STEP_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] meas_req,
  input wire logic [2:0] meas_done,
  input wire logic irq_wake_timer,
  input wire logic irq_amp_wake,
  input wire logic irq_phase_wake,
  input wire logic irq_cap_wake
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [31:0] gap_q; // cycles since the last timer event
  logic seen_q; // gap only means something after a first event
  // gap counter; a restart only lengthens the gap, so a minimum is safe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (irq_wake_timer) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  a_timer_pulse_one: assert property (irq_wake_timer |=> !irq_wake_timer)
    else $error("timer event longer than one cycle");
  a_timer_min_gap: assert property (irq_wake_timer && seen_q
    |-> gap_q >= FINE_STEP_CYCLES - 1)
    else $error("timer events closer than one step");
  a_amp_req_pulse: assert property (meas_req[2] |=> !meas_req[2])
    else $error("amplitude request longer than one cycle");
  a_amp_irq_cause: assert property (irq_amp_wake |-> $past(meas_done[2]))
    else $error("amplitude event without answer");
  a_phase_irq_cause: assert property (irq_phase_wake |-> $past(meas_done[1]))
    else $error("phase event without answer");
  a_cap_irq_cause: assert property (irq_cap_wake |-> $past(meas_done[0]))
    else $error("capacitance event without answer");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule : wtm_wakeup_timer_sva

bind wtm_wakeup_timer wtm_wakeup_timer_sva #(.FINE_STEP_CYCLES(FINE_STEP_CYCLES)) u_sva (
  .core_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .meas_req, .meas_done, .irq_wake_timer,
  .irq_amp_wake, .irq_phase_wake, .irq_cap_wake
);

// file: testbench/testbench.sv
/*
  testbench: self-checking bench for wtm_wakeup_timer.
  Assumes a shortened fine step and answers measurement requests itself.
*/
`timescale 1ns/100ps
module testbench;
  localparam int FS = 10; // short fine step keeps periods small
  logic core_clk, rst_n, awv, awr, wv, wr_q, bv, br, arv, arr, rv, rr;
  logic [9:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [2:0] req, done;
  logic [7:0] ares, pres, cres;
  logic it, ia, ip, ic;
  int n_mismatch, num_checks, cyc;
  wtm_wakeup_timer #(.FINE_STEP_CYCLES(FS)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_q), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .meas_req(req),
    .meas_done(done), .amp_result(ares), .phase_result(pres), .cap_result(cres),
    .irq_wake_timer(it), .irq_amp_wake(ia), .irq_phase_wake(ip), .irq_cap_wake(ic));
  // clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, bt;
    at = 0;
    wt = 0;
    bt = 0;
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!bt) begin
      @(negedge core_clk);
      at = at || (awv && awr);
      wt = wt || (wv && wr_q);
      bt = bv;
      r = bresp;
      @(posedge core_clk);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
    end
    br <= 1'b0;
    // let an edge pass so a following call never re-raises bready in this step
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at, t;
    t = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!t) begin
      @(negedge core_clk);
      at = arv && arr;
      t = rv;
      d = rd_d;
      r = rresp;
      @(posedge core_clk);
      if (at) arv <= 1'b0;
    end
    rr <= 1'b0;
    // let an edge pass so a following call never re-raises rready in this step
    @(posedge core_clk);
  endtask : rd
  task automatic chk_rd(input string nm, input logic [9:0] a, input int e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(nm, d, e);
    check("rresp", r, er);
  endtask : chk_rd
  function automatic int ad(input int a, input int b);
    return (a > b) ? a - b : b - a;
  endfunction : ad
  initial begin
    logic [1:0] r;
    int p, k, cfg, rf, pcd, prf, crf, res, pr, cr, av, refv, hit;
    logic [9:0] regs[5];
    rst_n = 1'b0;
    {awv, wv, br, arv, rr, done} = '0;
    {awa, ara, wd, ws, ares, pres, cres} = '0;
    regs = '{10'h0C8, 10'h0CC, 10'h0D0, 10'h0D4, 10'h0D8};
    void'($urandom(71304));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) chk_rd("reset_val", regs[i], 0, 2'h0);
    chk_rd("unmapped_rd", 10'h004, 0, 2'h2);
    wr(10'h004, 32'hFF, r);
    check("unmapped_wr", r, 2'h2);
    // every fine-range code, then both ends of the coarse range
    for (k = 0; k < 10; k++) begin
      logic [7:0] c;
      c = (k < 8) ? {1'b1, 3'(k), 4'h8} : {1'b0, (k == 8) ? 3'h0 : 3'h7, 4'h8};
      wr(10'h0C8, {24'h0, c}, r);
      chk_rd("ctrl", 10'h0C8, c, 2'h0);
      do begin @(negedge core_clk); p++; end while (!it && p < 2000);
      p = 0;
      do begin @(negedge core_clk); p++; end while (!it && p < 2000);
      check("period", p, (c[6:4] + 1) * (c[7] ? 1 : 10) * FS);
      p = 0;
      @(posedge core_clk);
    end
    av = 0;
    for (k = 0; k < 12; k++) begin
      cfg = ($urandom_range(255) & 32'hF9) | ((k % 4) << 1);
      // each register but the fixed capacitance reference drawn on its own, all within one byte; the weight code steps through 0..3
      rf = $urandom_range(255);
      pcd = $urandom_range(255);
      prf = $urandom_range(255);
      crf = 8'h80;
      wr(10'h0C8, 0, r);
      wr(10'h0CC, cfg, r);
      wr(10'h0D0, rf, r);
      wr(10'h0F0, pcd, r);
      wr(10'h0F4, prf, r);
      wr(10'h0F8, crf, r);
      wr(10'h0C8, 32'hF7, r);
      refv = cfg[0] ? av : rf;
      res = (refv + $urandom_range(40) + 236) & 255;
      pr = (prf + $urandom_range(16) + 248) & 255;
      cr = (crf + $urandom_range(16) + 248) & 255;
      p = 0;
      do begin @(negedge core_clk); p++; end while (req !== 3'h7 && p < 200);
      check("meas_req", req, 3'h7);
      check("quiet_timer", it, 1'b0);
      @(posedge core_clk);
      repeat ($urandom_range(2)) @(posedge core_clk);
      {ares, pres, cres} <= {res[7:0], pr[7:0], cr[7:0]};
      done <= 3'h7;
      @(posedge core_clk);
      done <= 3'h0;
      @(negedge core_clk);
      hit = ad(res, refv) > cfg[7:4];
      check("amp_irq", ia, hit);
      check("phase_irq", ip, ad(pr, prf) > pcd[7:4]);
      check("cap_irq", ic, ad(cr, crf) > pcd[3:0]);
      if (!hit || cfg[3]) av = av + ((res - av) >>> (2 + cfg[2:1]));
      @(posedge core_clk);
      wr(10'h0C8, 0, r);
      chk_rd("avg", 10'h0D4, av, 2'h0);
      chk_rd("amp_res", 10'h0D8, res, 2'h0);
      chk_rd("ph_res", 10'h0FC, pr, 2'h0);
      chk_rd("cap_res", 10'h100, cr, 2'h0);
    end
    // read-only display ignores writes but answers okay
    wr(10'h0D4, 32'h55, r);
    check("ro_wr", r, 2'h0);
    chk_rd("ro_avg", 10'h0D4, av, 2'h0);
    tally_and_finish();
  end
endmodule : testbench
